// >>> tws_pkg.sv
// Constants and types for the table-write and test-skip execution block
// Overview of operation
// - Zero test result discards the prefetched next instruction; a no-operation runs instead.
// - A taken zero skip over a one-word instruction stretches the test instruction to two cycles.
// - Bank-choice bit clear: operand lies in the access bank, bank select ignored.
// - Bank-choice bit set: bank select register picks the operand bank.
// - Bank-choice clear, extended set on, operand up to 95: indexed literal offset.
// - Smaller package variants treat table write as unavailable.
// - Larger variants allow table write only toward an external memory device.
// - Post-increment: write latch byte at current pointer, then add one.
// - Pre-increment: add one to pointer, then write latch byte there.
// - Skip over a two-word instruction takes three cycles, both words squashed.
package tws_pkg;

    localparam int TWS_AW = 6;
    // Register byte offsets
    localparam logic [TWS_AW-1:0] TWS_CTRL   = 6'h00;
    localparam logic [TWS_AW-1:0] TWS_FSR2   = 6'h04;
    localparam logic [TWS_AW-1:0] TWS_LATCH  = 6'h08;
    localparam logic [TWS_AW-1:0] TWS_PTR    = 6'h0c;
    localparam logic [TWS_AW-1:0] TWS_CMD    = 6'h10;
    localparam logic [TWS_AW-1:0] TWS_STATUS = 6'h14;
    localparam logic [TWS_AW-1:0] TWS_HOLDLO = 6'h18;
    localparam logic [TWS_AW-1:0] TWS_HOLDHI = 6'h1c;
    localparam logic [TWS_AW-1:0] TWS_DADDR  = 6'h20;
    localparam logic [TWS_AW-1:0] TWS_DDATA  = 6'h24;
    localparam logic [TWS_AW-1:0] TWS_EADDR  = 6'h28;

    // Field positions
    localparam int TWS_C_EXTENDED_SET_ENABLE  = 0;
    localparam int TWS_C_LARGE  = 1;
    localparam int TWS_C_EXTTGT = 2;
    localparam int TWS_C_BSR    = 8;
    localparam int TWS_K_TWOWD  = 16;
    localparam int TWS_S_BUSY   = 0;
    localparam int TWS_S_SKIP   = 1;
    localparam int TWS_S_UNAV   = 2;
    localparam int TWS_S_CYC    = 4;

    // Reset values
    localparam logic [31:0] TWS_CTRL_RST = 32'h0000_0000;
    localparam logic [20:0] TWS_PTR_RST  = 21'h00_0000;
    localparam logic [63:0] TWS_HOLD_RST = 64'hffff_ffff_ffff_ffff;

    // Opcode patterns, operand address limits and Q phase values
    localparam logic [6:0]  TWS_OP_TST   = 7'h33;
    localparam logic [13:0] TWS_OP_TABLE_WRITE_OP = 14'h0003;
    localparam logic [7:0]  TWS_ILO_MAX  = 8'h5f;
    localparam logic [3:0]  TWS_ACC_HI   = 4'hf;
    localparam logic [1:0]  TWS_Q_LAST   = 2'h3;
    localparam logic [1:0]  TWS_Q_READ   = 2'h1;

    typedef enum logic [1:0] {
        TWS_NOCHG,
        TWS_POSTINC,
        TWS_POSTDEC,
        TWS_PREINC
    } tws_mode_t;

    typedef struct packed {
        logic [3:0] bank_select_reg;
        logic       ext_target;
        logic       large_pkg;
        logic       extended_set_enable;
    } tws_cfg_t;

endpackage

// >>> tws_addr_resolve.sv
// Operand address resolution for the zero-test instruction
`timescale 1ns/1ps
`default_nettype none
module tws_addr_resolve
    import tws_pkg::*;
(
    input  wire tws_pkg::tws_cfg_t cfg,        // Bank and mode settings
    input  wire logic [11:0]       fsr2,       // Index base
    input  wire logic              bank_bit,   // Bank-choice opcode bit
    input  wire logic [7:0]        f_addr,     // Operand field
    output logic      [11:0]       eff_addr    // Data memory address
);
    always_comb
    begin
        if (bank_bit)
            eff_addr = {cfg.bank_select_reg, f_addr};
        else if (cfg.extended_set_enable && f_addr <= TWS_ILO_MAX)
            eff_addr = 12'(fsr2 + {4'h0, f_addr});
        else if (f_addr <= TWS_ILO_MAX)
            eff_addr = {4'h0, f_addr};
        else
            eff_addr = {TWS_ACC_HI, f_addr};
    end
endmodule
`default_nettype wire

// >>> tws_exec.sv
// Execution unit for table write and test-skip-if-zero with APB registers
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tws_exec
    import tws_pkg::*;
#(
    parameter int DMEM_DEPTH = 4096
)
(
    input  wire logic              pclk,      // Core clock, four per cycle
    input  wire logic              presetn,   // Async reset, active low
    input  wire logic              psel,      // APB select
    input  wire logic              penable,   // APB access phase
    input  wire logic              pwrite,    // APB direction
    input  wire logic [31:0]       paddr,     // APB byte address
    input  wire logic [31:0]       pwdata,    // APB write data
    output logic      [31:0]       prdata,    // APB read data
    output logic                   pready,    // APB ready
    output logic                   pslverr,   // APB error
    output logic                   squash,    // No-operation cycle active
    output logic      [1:0]        q_phase    // Current Q phase
);
    import tws_pkg::*;

    typedef enum logic [2:0] {
        TWS_IDLE,
        TWS_EXEC,
        TWS_SKIP1,
        TWS_SKIP2,
        TWS_TBLW2
    } tws_state_t;

    // ****************************************************************
    // Registers and wires
    // ****************************************************************
    tws_state_t  state;
    tws_cfg_t    cfg;
    logic [11:0] fsr2;
    logic [7:0]  table_latch_byte;
    logic [20:0] program_mem_pointer;
    logic [16:0] cmd;
    logic [63:0] hold;
    logic [11:0] daddr;
    logic [11:0] eaddr;
    logic [7:0]  operand;
    logic        skip_taken;
    logic        unavail;
    logic [1:0]  cyc_used;
    logic [1:0]  q;
    logic [7:0]  dmem [DMEM_DEPTH];
    logic [11:0] res_addr;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic        start;
    logic        is_tst;
    logic        is_table_write_op;
    logic        tbl_ok;
    logic        q_end;
    logic [20:0] next_ptr;
    logic [2:0]  byte_sel;
    tws_mode_t   mode;

    assign wr_en    = psel && penable && pwrite && paddr[31:TWS_AW] == '0;
    assign rd_en    = psel && penable && !pwrite && paddr[31:TWS_AW] == '0;
    assign pready   = 1'b1;
    assign is_tst   = cmd[15:9] == TWS_OP_TST;
    assign is_table_write_op = cmd[15:2] == TWS_OP_TABLE_WRITE_OP;
    assign mode     = tws_mode_t'(cmd[1:0]);
    assign tbl_ok   = cfg.large_pkg && cfg.ext_target;
    assign q_end    = q == TWS_Q_LAST;
    assign start    = wr_en && paddr[TWS_AW-1:0] == TWS_CMD
                      && state == TWS_IDLE;
    assign q_phase  = q;

    tws_addr_resolve u_resolve
    (
        .cfg      (cfg),
        .fsr2     (fsr2),
        .bank_bit (cmd[8]),
        .f_addr   (cmd[7:0]),
        .eff_addr (res_addr)
    );

    // Pointer update and holding byte selection
    always_comb
    begin
        next_ptr = program_mem_pointer;
        byte_sel = program_mem_pointer[2:0];
        case (mode)
            TWS_POSTINC: next_ptr = 21'(program_mem_pointer + 21'h1);
            TWS_POSTDEC: next_ptr = 21'(program_mem_pointer - 21'h1);
            TWS_PREINC:
            begin
                next_ptr = 21'(program_mem_pointer + 21'h1);
                byte_sel = next_ptr[2:0];
            end
            default:     next_ptr = program_mem_pointer;
        endcase
    end

    // ****************************************************************
    // Q phase counter
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= 2'h0;
        else if (start)
            q <= 2'h0;
        else
            q <= 2'(q + 2'h1);
    end

    // ****************************************************************
    // Instruction sequencer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= TWS_IDLE;
        else if (start)
            state <= TWS_EXEC;
        else if (q_end)
        begin
            case (state)
                TWS_EXEC:
                    if (is_tst && operand == 8'h00)
                        state <= TWS_SKIP1;
                    else if (is_table_write_op && tbl_ok)
                        state <= TWS_TBLW2;
                    else
                        state <= TWS_IDLE;
                TWS_SKIP1:
                    state <= cmd[TWS_K_TWOWD] ? TWS_SKIP2 : TWS_IDLE;
                default:
                    state <= TWS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            squash <= 1'b0;
        else
            squash <= (state == TWS_SKIP1 || state == TWS_SKIP2)
                      && !(q_end && state == TWS_SKIP2)
                      && !(q_end && state == TWS_SKIP1
                           && !cmd[TWS_K_TWOWD])
                      || (state == TWS_EXEC && q_end && is_tst
                          && operand == 8'h00);
    end

    // ****************************************************************
    // Operand fetch in Q2 of the first cycle
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            operand <= 8'h00;
            eaddr   <= 12'h000;
        end
        else if (state == TWS_EXEC && q == TWS_Q_READ && is_tst)
        begin
            operand <= dmem[res_addr];
            eaddr   <= res_addr;
        end
    end

    // ****************************************************************
    // Result status
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            skip_taken <= 1'b0;
            cyc_used   <= 2'h0;
        end
        else if (start)
        begin
            skip_taken <= 1'b0;
            cyc_used   <= 2'h0;
        end
        else if (q_end && state != TWS_IDLE)
        begin
            cyc_used <= 2'(cyc_used + 2'h1);
            if (state == TWS_EXEC && is_tst && operand == 8'h00)
                skip_taken <= 1'b1;
        end
    end

    // Sticky unavailable flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            unavail <= 1'b0;
        else if (state == TWS_EXEC && q_end && is_table_write_op && !tbl_ok)
            unavail <= 1'b1;
        else if (wr_en && paddr[TWS_AW-1:0] == TWS_STATUS
                 && pwdata[TWS_S_UNAV])
            unavail <= 1'b0;
    end

    // ****************************************************************
    // Table pointer and holding register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            program_mem_pointer <= TWS_PTR_RST;
        else if (state == TWS_TBLW2 && q_end)
            program_mem_pointer <= next_ptr;
        else if (wr_en && state == TWS_IDLE
                 && paddr[TWS_AW-1:0] == TWS_PTR)
            program_mem_pointer <= pwdata[20:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold <= TWS_HOLD_RST;
        else if (state == TWS_TBLW2 && q_end)
            hold[{byte_sel, 3'h0} +: 8] <= table_latch_byte;
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg              <= tws_cfg_t'(7'h00);
            fsr2             <= 12'h000;
            table_latch_byte <= 8'h00;
            cmd              <= 17'h00000;
            daddr            <= 12'h000;
        end
        else if (wr_en)
        begin
            case (paddr[TWS_AW-1:0])
                TWS_CTRL:
                begin
                    cfg.extended_set_enable <= pwdata[TWS_C_EXTENDED_SET_ENABLE];
                    cfg.large_pkg           <= pwdata[TWS_C_LARGE];
                    cfg.ext_target          <= pwdata[TWS_C_EXTTGT];
                    cfg.bank_select_reg     <= pwdata[TWS_C_BSR +: 4];
                end
                TWS_FSR2:  fsr2 <= pwdata[11:0];
                TWS_LATCH: if (state == TWS_IDLE)
                               table_latch_byte <= pwdata[7:0];
                TWS_CMD:   if (state == TWS_IDLE)
                               cmd <= pwdata[16:0];
                TWS_DADDR: daddr <= pwdata[11:0];
                default:   ;
            endcase
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_en && paddr[TWS_AW-1:0] == TWS_DDATA)
            dmem[daddr] <= pwdata[7:0];
    end

    // ****************************************************************
    // Read mux and error answer
    // ****************************************************************
    always_comb
    begin
        hit    = 1'b1;
        prdata = 32'h0000_0000;
        case (paddr[TWS_AW-1:0])
            TWS_CTRL:
                prdata = {20'h00000, cfg.bank_select_reg, 5'h00,
                          cfg.ext_target, cfg.large_pkg,
                          cfg.extended_set_enable};
            TWS_FSR2:   prdata = {20'h00000, fsr2};
            TWS_LATCH:  prdata = {24'h000000, table_latch_byte};
            TWS_PTR:    prdata = {11'h000, program_mem_pointer};
            TWS_CMD:    prdata = {15'h0000, cmd};
            TWS_STATUS: prdata = {26'h0000000, cyc_used, 1'b0, unavail,
                                  skip_taken, state != TWS_IDLE};
            TWS_HOLDLO: prdata = hold[31:0];
            TWS_HOLDHI: prdata = hold[63:32];
            TWS_DADDR:  prdata = {20'h00000, daddr};
            TWS_DDATA:  prdata = {24'h000000, dmem[daddr]};
            TWS_EADDR:  prdata = {20'h00000, eaddr};
            default:    hit = 1'b0;
        endcase
        if (!rd_en)
            prdata = 32'h0000_0000;
        pslverr = psel && penable && (!hit || paddr[31:TWS_AW] != '0);
    end
endmodule
`default_nettype wire

// >>> tws_exec_props.sv
// Checker on the ports of the table-write and test-skip block
`timescale 1ns/1ps
`default_nettype none
module tws_exec_props
    import tws_pkg::*;
(
    input wire logic        pclk,     // Clock
    input wire logic        presetn,  // Reset, active low
    input wire logic        psel,     // APB select
    input wire logic        penable,  // APB access phase
    input wire logic        pwrite,   // APB direction
    input wire logic [31:0] paddr,    // APB address
    input wire logic [31:0] pwdata,   // APB write data
    input wire logic [31:0] prdata,   // APB read data
    input wire logic        pready,   // APB ready
    input wire logic        pslverr,  // APB error
    input wire logic        squash,   // No-op slot
    input wire logic [1:0]  q_phase   // Q phase
);
    int  sq_len;
    wire logic acc = psel && penable;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sq_len <= 0;
        else if (squash)
            sq_len <= sq_len + 1;
        else
            sq_len <= 0;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY: assert property (acc |-> pready)
        else $error("pready low in access phase");
    AST_UNMAP: assert property (acc && paddr[31:6] != 26'h0 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPOK: assert property (acc && paddr == 32'h14 |-> !pslverr)
        else $error("error on mapped status read");
    AST_IDLE: assert property (!acc |-> prdata == 32'h0 && !pslverr)
        else $error("bus outputs active outside access");
    AST_SQ_Q1: assert property ($rose(squash) |-> q_phase == 2'h0)
        else $error("no-op slot not aligned to Q1");
    AST_SQ_MIN: assert property ($rose(squash) |-> squash [*4])
        else $error("no-op slot shorter than one cycle");
    AST_SQ_MAX: assert property (sq_len <= 8)
        else $error("no-op run longer than two cycles");
    AST_SQ_WHOLE: assert property ($fell(squash) && sq_len != 0 |-> sq_len == 4 || sq_len == 8)
        else $error("no-op run not whole cycles");
    AST_Q_STEP: assert property (squash && $past(squash) |-> q_phase == $past(q_phase) + 2'h1)
        else $error("Q phase stalled in no-op slot");
endmodule
`default_nettype wire

// >>> tws_fetch_model.sv
// Fetch-side model that counts squashed instruction slots
`timescale 1ns/1ps
`default_nettype none
module tws_fetch_model
(
    input  wire logic       pclk,        // Core clock
    input  wire logic       presetn,     // Reset, active low
    input  wire logic       squash,      // No-op slot flag
    input  wire logic [1:0] q_phase,     // Q phase
    output int              nop_cycles   // Discarded fetch slots
);
    // One discarded prefetch per no-op cycle seen at Q1
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nop_cycles <= 0;
        else if (squash && q_phase == 2'h0)
            nop_cycles <= nop_cycles + 1;
    end
endmodule
`default_nettype wire

// >>> table_write_test_skip_exec_tb_top.sv
// Self-checking bench for the table-write and test-skip block
`timescale 1ns/1ps
`default_nettype none
module table_write_test_skip_exec_tb_top;
    import tws_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        squash, e;
    logic [31:0] paddr, pwdata, prdata, r, st;
    logic [1:0]  q_phase;
    logic [63:0] hold;
    logic [20:0] p, np;
    logic [2:0]  b;
    logic [7:0]  lat;
    int          n_fail, n_tests, nop_cycles;
    tws_exec u_tws_exec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .squash, .q_phase);
    tws_fetch_model u_tws_fetch_model (.pclk, .presetn, .squash, .q_phase,
        .nop_cycles);
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        apb(1'b1, {26'h0, a}, d);
    endtask
    task automatic chk(input logic [5:0] a, input logic [31:0] x);
        apb(1'b0, {26'h0, a}, 32'h0);
        cmp(r, x);
        cmp({31'h0, e}, 32'h0);
    endtask
    task automatic run(input logic [31:0] cmd);
        wr(TWS_CMD, cmd);
        st = 32'h1;
        while (st[TWS_S_BUSY] !== 1'b0)
        begin
            apb(1'b0, {26'h0, TWS_STATUS}, 32'h0);
            st = r;
        end
    endtask
    task automatic tst(input logic [31:0] c, input logic a, input logic [7:0] f,
        input logic two, input logic [7:0] d, input logic [11:0] ea);
        int n0;
        wr(TWS_CTRL, c);
        wr(TWS_DADDR, {20'h0, ea});
        wr(TWS_DDATA, {24'h0, d});
        n0 = nop_cycles;
        run({15'h0, two, TWS_OP_TST, a, f});
        chk(TWS_STATUS, d != 8'h0 ? 32'h10 : two ? 32'h32 : 32'h22);
        chk(TWS_EADDR, {20'h0, ea});
        cmp(32'(nop_cycles - n0), d != 8'h0 ? 32'h0 : two ? 32'h2 : 32'h1);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        n_fail = 0;
        n_tests = 0;
        hold = '1;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk(TWS_CTRL, 32'h0);
        chk(TWS_PTR, 32'h0);
        chk(TWS_HOLDLO, 32'hffff_ffff);
        chk(TWS_STATUS, 32'h0);
        apb(1'b0, 32'h0000_002c, 32'h0);
        cmp({r[30:0], e}, 32'h1);
        apb(1'b1, 32'h0000_0100, 32'h0000_0f06);
        cmp({31'h0, e}, 32'h1);
        chk(TWS_CTRL, 32'h0);
        for (int c = 0; c < 2; c++)
        begin
            wr(TWS_CTRL, c == 0 ? 32'h4 : 32'h2);
            wr(TWS_PTR, 32'h5);
            wr(TWS_LATCH, 32'h55);
            run({16'h0, TWS_OP_TABLE_WRITE_OP, 2'h1});
            chk(TWS_STATUS, 32'h14);
            chk(TWS_PTR, 32'h5);
            wr(TWS_STATUS, 32'h4);
            chk(TWS_STATUS, 32'h10);
        end
        wr(TWS_CTRL, 32'h6);
        apb(1'b0, 32'h0000_0100, 32'h0);
        cmp({r[30:0], e}, 32'h1);
        for (int nn = 0; nn < 4; nn++)
        begin
            p = 21'h1f_fffc + 21'(nn);
            np = (nn == 1 || nn == 3) ? p + 21'h1 : nn == 2 ? p - 21'h1 : p;
            b = nn == 3 ? np[2:0] : p[2:0];
            lat = 8'(17 * (nn + 1));
            hold[b * 8 +: 8] = lat;
            wr(TWS_PTR, {11'h0, p});
            wr(TWS_LATCH, {24'h0, lat});
            run({16'h0, TWS_OP_TABLE_WRITE_OP, 2'(nn)});
            chk(TWS_STATUS, 32'h20);
            chk(TWS_PTR, {11'h0, np});
            chk(TWS_HOLDLO, hold[31:0]);
            chk(TWS_HOLDHI, hold[63:32]);
        end
        wr(TWS_FSR2, 32'h200);
        tst(32'h300, 1'b1, 8'h10, 1'b0, 8'h0, 12'h310);
        tst(32'h300, 1'b1, 8'h10, 1'b1, 8'h0, 12'h310);
        tst(32'h300, 1'b1, 8'h10, 1'b0, 8'h1, 12'h310);
        tst(32'h000, 1'b0, 8'h20, 1'b0, 8'h0, 12'h020);
        tst(32'h300, 1'b0, 8'h80, 1'b0, 8'h0, 12'hf80);
        tst(32'h301, 1'b0, 8'h5f, 1'b0, 8'h0, 12'h25f);
        tst(32'h301, 1'b0, 8'h60, 1'b1, 8'h0, 12'hf60);
        tst(32'h301, 1'b1, 8'h05, 1'b0, 8'h7, 12'h305);
        // Mid-run reset brings registers back to their reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(TWS_CTRL, 32'h0);
        chk(TWS_HOLDHI, 32'hffff_ffff);
        chk(TWS_STATUS, 32'h0);
        test_done;
    end
    initial
    begin
        #200us;
        n_fail++;
        test_done;
    end
endmodule
bind tws_exec tws_exec_props u_tws_exec_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .squash,
    .q_phase);
`default_nettype wire
